// ### hdl/sme_pkg.sv
// Behaviour
// - code 111+index ORs write mailbox into that parameter, result to read mailbox.
// - no-operation code writes zero into the response register.
// - reset code resets the sequencer state.
// - forced proximity code measures enabled proximity channels once.
// - forced ambient code measures enabled visible, infrared and auxiliary channels once.
// - combined forced code measures both groups once, proximity first.
// - auto codes start proximity, ambient or both autonomous loops.
// - good completion of a merge, forced, auto or pause code keeps upper nibble zero and bumps a wrapping low-nibble counter.
// - no-operation resets the completion counter to zero.
// - invalid setting reports 0x80 and holds it until a no-operation or reset code.
// - proximity channel overflows report 0x88, 0x89, 0x8A.
// - visible overflow reports 0x8C, infrared overflow 0x8D.
// - auxiliary overflow reports 0x8E.
// - channel list bits 0-2 enable proximity, bits 4-6 visible, infrared, auxiliary.
// - proximity interrupt flags at status bits 2-4, gated by enable bits 2-4.
// - ambient interrupt uses status and enable bits 1:0, mode in bits 2:0.
// - proximity modes in mode-a bits 5:4, 7:6 and mode-b bits 1:0.
// - 8-bit thresholds, hysteresis, history, wake interval and group rates exist.
// - only a command write or a due autonomous loop wakes the sequencer.
package sme_pkg;
  localparam logic [7:0] CMD_NOP    = 8'h00;
  localparam logic [7:0] CMD_RESET  = 8'h01;
  localparam logic [7:0] CMD_ADDR   = 8'h02;
  localparam logic [7:0] CMD_F_PROX = 8'h05;
  localparam logic [7:0] CMD_F_AMB  = 8'h06;
  localparam logic [7:0] CMD_F_BOTH = 8'h07;
  localparam logic [7:0] CMD_P_PROX = 8'h09;
  localparam logic [7:0] CMD_P_AMB  = 8'h0A;
  localparam logic [7:0] CMD_P_BOTH = 8'h0B;
  localparam logic [7:0] CMD_A_PROX = 8'h0D;
  localparam logic [7:0] CMD_A_AMB  = 8'h0E;
  localparam logic [7:0] CMD_A_BOTH = 8'h0F;
  localparam logic [2:0] OP_MERGE_OR = 3'h7;
  localparam logic [7:0] RSP_RESET   = 8'h00;
  localparam logic [7:0] RSP_INVALID = 8'h80;
  localparam logic [7:0] RSP_OVF_BASE = 8'h88;
  localparam logic [6:0] CH_PROX_MASK = 7'h07;
  localparam logic [6:0] CH_AMB_MASK  = 7'h70;
  localparam logic [2:0] CH_VISIBLE   = 3'h4;
  // parameter ram indices
  localparam logic [4:0] PIX_CHANNEL_LIST_PARAM    = 5'h01;
  localparam logic [4:0] PIX_TH1       = 5'h02;
  localparam logic [4:0] PIX_PROX_HYST = 5'h05;
  localparam logic [4:0] PIX_PROX_HIST = 5'h06;
  localparam logic [4:0] PIX_AMB_HYST  = 5'h07;
  localparam logic [4:0] PIX_AMB_HIST  = 5'h08;
  localparam logic [4:0] PIX_WAKE      = 5'h09;
  localparam logic [4:0] PIX_PROX_RATE = 5'h0A;
  localparam logic [4:0] PIX_AMB_RATE  = 5'h0B;
  localparam int unsigned IRQ_AMB_LSB   = 0;
  localparam int unsigned IRQ_PROX1_BIT = 2;
  localparam int unsigned MODEA_AMB_LSB = 0;
  localparam int unsigned MODEA_P1_LSB  = 4;
  localparam int unsigned MODEA_P2_LSB  = 6;
  localparam int unsigned MODEB_P3_LSB  = 0;
  localparam logic [1:0] PMODE_EVERY = 2'h0;
  localparam logic [1:0] PMODE_CROSS = 2'h1;
  localparam logic [1:0] PMODE_ABOVE = 2'h3;
  localparam logic [6:0] ADDR_RESET  = 7'h30; // arbitrary
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned WAKE_TICK_NS  = 100000;
  localparam int unsigned WAKE_TICK_CYC = WAKE_TICK_NS / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DECODE = 3'b001,
    ST_MEAS   = 3'b010,
    ST_WAIT   = 3'b011,
    ST_FINISH = 3'b100
  } sme_state_type;
endpackage

// ### hdl/sme_toggle_sync.sv
`timescale 1ns/1ps
module sme_toggle_sync (
  // source side
  input  wire logic src_clk_in,
  input  wire logic src_pulse_in,
  // destination side
  input  wire logic dst_clk_in,
  input  wire logic arst_n_in,
  output wire logic dst_pulse_out
);
  logic src_tgl_ff;
  logic [2:0] dst_sync_ff;

  always_ff @(posedge src_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) src_tgl_ff <= 1'b0;
    else if (src_pulse_in) src_tgl_ff <= ~src_tgl_ff;
  end

  // stage 0 feeds only stage 1
  always_ff @(posedge dst_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) dst_sync_ff <= 3'h0;
    else dst_sync_ff <= {dst_sync_ff[1:0], src_tgl_ff};
  end

  assign dst_pulse_out = dst_sync_ff[2] ^ dst_sync_ff[1];
endmodule

// ### hdl/sme_param_ram.sv
`timescale 1ns/1ps
module sme_param_ram (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  // write side
  input  wire logic       clear_in,
  input  wire logic       wr_en_in,
  input  wire logic [4:0] wr_idx_in,
  input  wire logic [7:0] wr_data_in,
  // read ports
  input  wire logic [4:0] a_idx_in,
  output wire logic [7:0] a_data_out,
  input  wire logic [4:0] b_idx_in,
  output wire logic [7:0] b_data_out,
  output wire logic [7:0] channel_list_param_out,
  output wire logic [7:0] wake_out,
  output wire logic [7:0] prox_rate_out,
  output wire logic [7:0] amb_rate_out
);
  import sme_pkg::*;
  logic [7:0] mem_ff [32];

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < 32; i++) mem_ff[i] <= 8'h00;
    end else if (clear_in) begin
      for (int i = 0; i < 32; i++) mem_ff[i] <= 8'h00;
    end else if (wr_en_in) begin
      mem_ff[wr_idx_in] <= wr_data_in;
    end
  end

  assign a_data_out    = mem_ff[a_idx_in];
  assign b_data_out    = mem_ff[b_idx_in];
  assign channel_list_param_out    = mem_ff[PIX_CHANNEL_LIST_PARAM];
  assign wake_out      = mem_ff[PIX_WAKE];
  assign prox_rate_out = mem_ff[PIX_PROX_RATE];
  assign amb_rate_out  = mem_ff[PIX_AMB_RATE];
endmodule

// ### hdl/sme_mailbox.sv
`timescale 1ns/1ps
module sme_mailbox #(
  parameter int unsigned WAKE_TICK_CYCLES = sme_pkg::WAKE_TICK_CYC
) (
  // core clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       arst_n_in,
  // link side command write
  input  wire logic       lnk_clk_in,
  input  wire logic       lnk_cmd_wr_in,
  input  wire logic [7:0] lnk_cmd_in,
  input  wire logic [7:0] lnk_param_write_mailbox_in,
  // measurement path
  output wire logic       meas_req_out,
  output wire logic [2:0] meas_chan_out,
  input  wire logic       meas_done_in,
  input  wire logic       meas_ovf_in,
  input  wire logic [7:0] meas_value_in,
  // interrupt resources
  input  wire logic [4:0] int_allow_in,
  input  wire logic [7:0] int_mode_register_a_in,
  input  wire logic [7:0] int_mode_register_b_in,
  input  wire logic [4:0] int_clear_in,
  output wire logic [4:0] int_status_out,
  // status
  output wire logic [7:0] response_out,
  output wire logic [7:0] param_read_mailbox_out,
  output wire logic [6:0] slave_address_out,
  output wire logic       auto_prox_out,
  output wire logic       auto_amb_out,
  output wire logic       sequencer_awake_out
);
  import sme_pkg::*;

  function automatic logic [2:0] first_chan(input logic [6:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 6; i >= 0; i--) if (m[i]) r = 3'(i);
    return r;
  endfunction

  // link domain: words stay put until the next command write
  logic [7:0] lnk_cmd_ff;
  logic [7:0] lnk_pwr_ff;
  logic       cmd_evt;

  always_ff @(posedge lnk_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lnk_cmd_ff <= 8'h00;
      lnk_pwr_ff <= 8'h00;
    end else if (lnk_cmd_wr_in) begin
      lnk_cmd_ff <= lnk_cmd_in;
      lnk_pwr_ff <= lnk_param_write_mailbox_in;
    end
  end

  sme_toggle_sync u_cmd_sync (
    .src_clk_in    (lnk_clk_in),
    .src_pulse_in  (lnk_cmd_wr_in),
    .dst_clk_in    (ref_clk_in),
    .arst_n_in     (arst_n_in),
    .dst_pulse_out (cmd_evt)
  );

  // core domain state
  sme_state_type state_ff;
  sme_state_type nxt_state;
  logic [7:0] cmd_ff;
  logic [7:0] pwr_ff;
  logic [7:0] rsp_ff;
  logic [7:0] nxt_rsp;
  logic [7:0] prd_ff;
  logic [6:0] addr_ff;
  logic       auto_prox_ff;
  logic       auto_amb_ff;
  logic       auto_run_ff;
  logic [6:0] todo_ff;
  logic [6:0] nxt_todo;
  logic [2:0] chan_ff;
  logic       req_ff;
  logic [7:0] err_ff;
  logic [7:0] nxt_err;
  logic [4:0] irq_ff;
  logic [2:0] above_ff;
  logic       due_ff;
  logic [12:0] tick_ff;
  logic [7:0] unit_ff;

  // parameter ram hookup
  logic [7:0] ram_a;
  logic [7:0] ram_b;
  logic [7:0] channel_list_param;
  logic [7:0] wake;
  logic [7:0] prox_rate;
  logic [7:0] amb_rate;
  wire  [4:0] or_idx  = cmd_ff[4:0];
  wire  [4:0] th_idx  = PIX_TH1 + {3'h0, chan_ff[1:0]};
  wire  [7:0] merged  = ram_a | pwr_ff;
  wire        in_dec  = (state_ff == ST_DECODE);
  wire        dec_or  = in_dec && (cmd_ff[7:5] == OP_MERGE_OR);
  wire        dec_nop = in_dec && (cmd_ff == CMD_NOP);
  wire        dec_rst = in_dec && (cmd_ff == CMD_RESET);
  wire        dec_adr = in_dec && (cmd_ff == CMD_ADDR);
  wire        dec_fp  = in_dec && (cmd_ff == CMD_F_PROX || cmd_ff == CMD_F_BOTH);
  wire        dec_fa  = in_dec && (cmd_ff == CMD_F_AMB || cmd_ff == CMD_F_BOTH);
  wire        dec_frc = dec_fp || dec_fa;
  wire        dec_pp  = in_dec && (cmd_ff == CMD_P_PROX || cmd_ff == CMD_P_BOTH);
  wire        dec_pa  = in_dec && (cmd_ff == CMD_P_AMB || cmd_ff == CMD_P_BOTH);
  wire        dec_ap  = in_dec && (cmd_ff == CMD_A_PROX || cmd_ff == CMD_A_BOTH);
  wire        dec_aa  = in_dec && (cmd_ff == CMD_A_AMB || cmd_ff == CMD_A_BOTH);
  wire        dec_loop = dec_pp || dec_pa || dec_ap || dec_aa;
  // channel list gates both groups
  wire  [6:0] frc_set = channel_list_param[6:0] & ({7{dec_fp}} & CH_PROX_MASK | {7{dec_fa}} & CH_AMB_MASK);
  wire  [6:0] auto_set = channel_list_param[6:0] & ({7{auto_prox_ff && prox_rate != 8'h00}} & CH_PROX_MASK
                                      | {7{auto_amb_ff && amb_rate != 8'h00}} & CH_AMB_MASK);
  wire        done_now = (state_ff == ST_WAIT) && meas_done_in;
  wire        loop_on  = (auto_prox_ff || auto_amb_ff) && wake != 8'h00;
  wire        tick_end = (tick_ff == 13'(WAKE_TICK_CYCLES - 1));

  sme_param_ram u_ram (
    .clk_in        (ref_clk_in),
    .arst_n_in     (arst_n_in),
    .clear_in      (dec_rst),
    .wr_en_in      (dec_or),
    .wr_idx_in     (or_idx),
    .wr_data_in    (merged),
    .a_idx_in      (or_idx),
    .a_data_out    (ram_a),
    .b_idx_in      (th_idx),
    .b_data_out    (ram_b),
    .channel_list_param_out    (channel_list_param),
    .wake_out      (wake),
    .prox_rate_out (prox_rate),
    .amb_rate_out  (amb_rate)
  );

  // sequencer next state; idle leaves only on a command or a due loop
  always_comb begin
    nxt_state = state_ff;
    nxt_todo  = todo_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (cmd_evt) nxt_state = ST_DECODE;
        else if (due_ff && auto_set != 7'h00) begin
          nxt_todo  = auto_set;
          nxt_state = ST_MEAS;
        end
      end
      ST_DECODE: begin
        nxt_state = ST_IDLE;
        if (dec_or || dec_loop) nxt_state = ST_FINISH;
        else if (dec_frc) begin
          nxt_todo  = frc_set;
          nxt_state = (frc_set == 7'h00) ? ST_FINISH : ST_MEAS;
        end
      end
      ST_MEAS: nxt_state = ST_WAIT;
      ST_WAIT: begin
        if (meas_done_in) begin
          nxt_todo  = todo_ff & ~(7'h01 << chan_ff);
          nxt_state = (nxt_todo == 7'h00) ? ST_FINISH : ST_MEAS;
        end
      end
      ST_FINISH: nxt_state = ST_IDLE;
    endcase
  end

  // first error of a command wins
  always_comb begin
    nxt_err = err_ff;
    if (dec_frc) nxt_err = (frc_set == 7'h00) ? RSP_INVALID : 8'h00;
    else if (in_dec) nxt_err = 8'h00;
    else if (done_now && meas_ovf_in && err_ff == 8'h00)
      nxt_err = RSP_OVF_BASE + {5'h00, chan_ff};
  end

  // errors stay until a no-operation or reset code clears them
  always_comb begin
    nxt_rsp = rsp_ff;
    if (dec_nop) nxt_rsp = 8'h00;
    else if (state_ff == ST_FINISH && !auto_run_ff && rsp_ff[7:4] == 4'h0) begin
      if (err_ff != 8'h00) nxt_rsp = err_ff;
      else nxt_rsp = {4'h0, rsp_ff[3:0] + 4'h1};
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= ST_IDLE;
      todo_ff  <= 7'h00;
      err_ff   <= 8'h00;
      rsp_ff   <= RSP_RESET;
      cmd_ff   <= 8'h00;
      pwr_ff   <= 8'h00;
    end else begin
      state_ff <= dec_rst ? ST_IDLE : nxt_state;
      todo_ff  <= nxt_todo;
      err_ff   <= nxt_err;
      rsp_ff   <= dec_rst ? RSP_RESET : nxt_rsp;
      if (cmd_evt && state_ff == ST_IDLE) begin
        cmd_ff <= lnk_cmd_ff;
        pwr_ff <= lnk_pwr_ff;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prd_ff       <= 8'h00;
      addr_ff      <= ADDR_RESET;
      auto_prox_ff <= 1'b0;
      auto_amb_ff  <= 1'b0;
      auto_run_ff  <= 1'b0;
    end else begin
      if (dec_or) prd_ff <= merged;
      if (dec_adr) addr_ff <= pwr_ff[6:0];
      if (dec_rst || dec_pp) auto_prox_ff <= 1'b0;
      else if (dec_ap) auto_prox_ff <= 1'b1;
      if (dec_rst || dec_pa) auto_amb_ff <= 1'b0;
      else if (dec_aa) auto_amb_ff <= 1'b1;
      if (in_dec) auto_run_ff <= 1'b0;
      else if (state_ff == ST_IDLE && !cmd_evt && due_ff) auto_run_ff <= 1'b1;
    end
  end

  // wake timer; a start or restart command realigns it
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_ff <= 13'h0000;
      unit_ff <= 8'h00;
      due_ff  <= 1'b0;
    end else if (!loop_on || dec_ap || dec_aa) begin
      tick_ff <= 13'h0000;
      unit_ff <= 8'h00;
      due_ff  <= 1'b0;
    end else begin
      tick_ff <= tick_end ? 13'h0000 : tick_ff + 13'h0001;
      if (tick_end) unit_ff <= (unit_ff == wake - 8'h01) ? 8'h00 : unit_ff + 8'h01;
      // a command in progress only delays the loop; a start code, or both loops stopping, drops it
      if (tick_end && unit_ff == wake - 8'h01) due_ff <= 1'b1;
      else if (state_ff == ST_IDLE && !cmd_evt) due_ff <= 1'b0;
    end
  end

  // channel handshake with the analog path
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      chan_ff <= 3'h0;
      req_ff  <= 1'b0;
    end else if (state_ff == ST_MEAS) begin
      chan_ff <= first_chan(todo_ff);
      req_ff  <= 1'b1;
    end else if (meas_done_in || dec_rst) begin
      req_ff  <= 1'b0;
    end
  end

  // interrupt flags: set wins over a same-cycle clear
  wire [1:0] pmode [3];
  assign pmode[0] = int_mode_register_a_in[MODEA_P1_LSB +: 2];
  assign pmode[1] = int_mode_register_a_in[MODEA_P2_LSB +: 2];
  assign pmode[2] = int_mode_register_b_in[MODEB_P3_LSB +: 2];
  wire       is_above = meas_value_in > ram_b;
  wire       amb_hit  = done_now && chan_ff == CH_VISIBLE
                        && int_mode_register_a_in[MODEA_AMB_LSB +: 3] == 3'h0;
  wire [4:0] irq_set;
  assign irq_set[IRQ_AMB_LSB +: 2] = {1'b0, amb_hit} & int_allow_in[IRQ_AMB_LSB +: 2];

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_prox
      wire hit = done_now && chan_ff == 3'(g);
      assign irq_set[IRQ_PROX1_BIT + g] = hit && int_allow_in[IRQ_PROX1_BIT + g] &&
        (pmode[g] == PMODE_EVERY || (pmode[g] == PMODE_ABOVE && is_above)
         || (pmode[g] == PMODE_CROSS && is_above != above_ff[g]));
      always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) above_ff[g] <= 1'b0;
        else if (hit) above_ff[g] <= is_above;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) irq_ff <= 5'h00;
    else irq_ff <= (irq_ff & ~int_clear_in) | irq_set;
  end

  assign meas_req_out           = req_ff;
  assign meas_chan_out          = chan_ff;
  assign int_status_out         = irq_ff;
  assign response_out           = rsp_ff;
  assign param_read_mailbox_out = prd_ff;
  assign slave_address_out      = addr_ff;
  assign auto_prox_out          = auto_prox_ff;
  assign auto_amb_out           = auto_amb_ff;
  assign sequencer_awake_out    = (state_ff != ST_IDLE);

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_forced_ok;
    dec_frc && frc_set != 7'h00 && rsp_ff[7:4] == 4'h0;
  endsequence

  a_nop_clears_rsp: assert property (dec_nop |=> rsp_ff == 8'h00)
    else $error("nop did not clear response");
  a_merge_or_write: assert property (dec_or |=> prd_ff == $past(ram_a | pwr_ff))
    else $error("merge result wrong");
  a_forced_starts: assert property (s_forced_ok |=> state_ff == ST_MEAS ##1 req_ff)
    else $error("forced measurement did not start");
  a_ok_increments: assert property ((state_ff == ST_FINISH && !auto_run_ff && rsp_ff[7:4] == 4'h0
    && err_ff == 8'h00 && !dec_rst) |=> rsp_ff == {4'h0, $past(rsp_ff[3:0]) + 4'h1})
    else $error("counter not incremented");
  a_err_held: assert property ((rsp_ff[7] && !dec_nop && !dec_rst) |=> rsp_ff == $past(rsp_ff))
    else $error("error code not held");
  a_empty_invalid: assert property ((dec_frc && frc_set == 7'h00 && rsp_ff[7:4] == 4'h0)
    |=> ##1 rsp_ff == RSP_INVALID)
    else $error("empty channel list not reported");
  a_ovf_code: assert property ((done_now && meas_ovf_in && err_ff == 8'h00)
    |=> err_ff == RSP_OVF_BASE + {5'h00, $past(chan_ff)})
    else $error("overflow code wrong");
  a_addr_change: assert property (dec_adr |=> slave_address_out == $past(pwr_ff[6:0])
    && rsp_ff == $past(rsp_ff))
    else $error("address command wrong");
  a_pause_stops: assert property (dec_pp |=> !auto_prox_ff)
    else $error("proximity loop not paused");
  a_auto_starts: assert property ((dec_aa && !dec_pa) |=> auto_amb_ff)
    else $error("ambient loop not started");
  a_reset_clears: assert property (dec_rst |=> !auto_prox_ff && !auto_amb_ff
    && rsp_ff == RSP_RESET && state_ff == ST_IDLE)
    else $error("reset left state behind");
  a_idle_no_wake: assert property ((state_ff == ST_IDLE && !cmd_evt && !due_ff)
    |=> state_ff == ST_IDLE)
    else $error("woke without a command");
  a_chan_enabled: assert property ($rose(req_ff) |-> channel_list_param[chan_ff])
    else $error("disabled channel measured");
  a_irq_prox_set: assert property (irq_set[IRQ_PROX1_BIT] |=> irq_ff[IRQ_PROX1_BIT])
    else $error("proximity flag lost");
endmodule

// ### verif/sme_meas_model.sv
`timescale 1ns/1ps
module sme_meas_model (
  // core side
  input  wire logic       clk_in,
  input  wire logic       req_in,
  input  wire logic [2:0] chan_in,
  input  wire logic [2:0] ovf_chan_in,
  // answer
  output logic            done_out,
  output logic            ovf_out,
  output logic [7:0]      value_out
);
  logic [23:0] seen = '0;
  logic [2:0]  wait_q = '0;
  logic        slow = 1'b0;
  initial begin
    done_out = 1'b0;
    ovf_out = 1'b0;
    value_out = 8'h5A;
  end
  // answers alternate prompt and slow; value toggles outside done so a stale sample shows
  always @(negedge clk_in) begin
    done_out <= 1'b0;
    ovf_out <= 1'b0;
    value_out <= ~value_out;
    if (req_in && !done_out) begin
      if (wait_q == 3'h0) begin
        done_out <= 1'b1;
        ovf_out <= (chan_in == ovf_chan_in);
        value_out <= 8'h40;
        seen <= {seen[19:0], 1'b0, chan_in};
        slow <= ~slow;
        wait_q <= slow ? 3'h0 : 3'h5;
      end else begin
        wait_q <= wait_q - 3'h1;
      end
    end
  end
endmodule

// ### verif/tb_sensor_command_mailbox.sv
`timescale 1ns/1ps
module tb_sensor_command_mailbox;
  import sme_pkg::*;
  logic       ref_clk = 0, lnk_clk = 0, arst_n = 0, wr = 0, done, ovf, req, ap, aa, awake;
  logic [7:0] code = 0, wmb = 0, value, mode_a = 0, mode_b = 0, rsp, rmb;
  logic [4:0] allow = 0, iclr = 0, ist;
  logic [2:0] chan, ovf_ch = 3'h7;
  logic [6:0] sadr;
  int         n_errors = 0, comparisons = 0;
  logic [7:0] rsv[6] = '{8'h03, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1F};
  logic [7:0] lp_cmd[8] = '{CMD_A_PROX, CMD_P_PROX, CMD_A_AMB, CMD_P_AMB, CMD_A_BOTH, CMD_P_BOTH,
                            CMD_A_BOTH, CMD_P_PROX};
  logic [1:0] lp_exp[8] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h3, 2'h0, 2'h3, 2'h1};
  logic [7:0] f_cmd[3] = '{CMD_F_PROX, CMD_F_AMB, CMD_F_BOTH};
  logic [23:0] f_seen[3] = '{24'h000012, 24'h000456, 24'h012456};
  logic [4:0] f_int[3] = '{5'h1C, 5'h01, 5'h1D};
  logic [2:0] ovc[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  always #10 ref_clk = ~ref_clk;
  always #16 lnk_clk = ~lnk_clk;
  sme_mailbox #(.WAKE_TICK_CYCLES(4)) dut (
    .ref_clk_in(ref_clk), .arst_n_in(arst_n), .lnk_clk_in(lnk_clk), .lnk_cmd_wr_in(wr),
    .lnk_cmd_in(code), .lnk_param_write_mailbox_in(wmb), .meas_req_out(req), .meas_chan_out(chan),
    .meas_done_in(done), .meas_ovf_in(ovf), .meas_value_in(value), .int_allow_in(allow),
    .int_mode_register_a_in(mode_a), .int_mode_register_b_in(mode_b), .int_clear_in(iclr),
    .int_status_out(ist), .response_out(rsp), .param_read_mailbox_out(rmb),
    .slave_address_out(sadr), .auto_prox_out(ap), .auto_amb_out(aa), .sequencer_awake_out(awake));
  sme_meas_model u_meas (.clk_in(ref_clk), .req_in(req), .chan_in(chan), .ovf_chan_in(ovf_ch),
    .done_out(done), .ovf_out(ovf), .value_out(value));
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask
  task automatic close_out;
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one command write, then wait for the sequencer to go back to standby
  task automatic run(input logic [7:0] c, input logic [7:0] m);
    int k;
    @(negedge lnk_clk);
    code = c;
    wmb = m;
    wr = 1'b1;
    @(negedge lnk_clk);
    wr = 1'b0;
    repeat (8) @(negedge ref_clk);
    k = 0;
    while (awake !== 1'b0 && k < 500) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 500) chk("completion", 0, 1);
  endtask
  // host sequence: clear, confirm zero, then the command itself
  // a response still zero after the command means it was lost: start the whole sequence again, once at most
  task automatic cmdp(input logic [7:0] c, input logic [7:0] m);
    int tries;
    tries = 0;
    do begin
      run(CMD_NOP, 8'h00);
      chk("cleared response", RSP_RESET, rsp);
      run(c, m);
      tries++;
    end while (rsp === 8'h00 && tries < 2);
  endtask
  task automatic int_clear;
    @(negedge ref_clk);
    iclr = 5'h1F;
    @(negedge ref_clk);
    iclr = 5'h00;
    @(negedge ref_clk);
  endtask
  initial begin
    #1800000;
    n_errors++;
    close_out;
  end
  initial begin
    repeat (3) @(negedge ref_clk);
    arst_n = 1'b1;
    chk("response", RSP_RESET, rsp);
    chk("address", ADDR_RESET, sadr);
    cmdp({OP_MERGE_OR, PIX_CHANNEL_LIST_PARAM}, 8'h05);
    chk("read mailbox", 8'h05, rmb);
    chk("response", 8'h01, rsp);
    cmdp({OP_MERGE_OR, PIX_CHANNEL_LIST_PARAM}, 8'h72);
    chk("read mailbox", 8'h77, rmb);
    run(CMD_NOP, 8'h00);
    for (int i = 1; i <= 17; i++) begin
      run({OP_MERGE_OR, PIX_AMB_HIST}, 8'h00);
      chk("counter", i % 16, rsp);
    end
    cmdp(CMD_F_BOTH, 8'h00);
    chk("gated status", 0, ist);
    allow = 5'h1D;
    for (int i = 0; i < 3; i++) begin
      u_meas.seen = '0;
      cmdp(f_cmd[i], 8'h00);
      chk("channel order", f_seen[i], u_meas.seen);
      chk("response", 8'h01, rsp);
      chk("int status", f_int[i], ist);
      int_clear;
      chk("cleared status", 0, ist);
    end
    for (int i = 0; i < 6; i++) begin
      ovf_ch = ovc[i];
      cmdp(CMD_F_BOTH, 8'h00);
      chk("overflow code", RSP_OVF_BASE + ovc[i], rsp);
      run({OP_MERGE_OR, PIX_AMB_HIST}, 8'h00);
      chk("held error", RSP_OVF_BASE + ovc[i], rsp);
    end
    ovf_ch = 3'h7;
    int_clear;
    cmdp({OP_MERGE_OR, PIX_AMB_HIST}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      run(rsv[i], 8'h00);
      chk("reserved", 8'h01, rsp);
    end
    run(CMD_ADDR, 8'h25);
    chk("address cmd", 8'h01, rsp);
    chk("new address", 7'h25, sadr);
    for (int i = 0; i < 8; i++) begin
      cmdp(lp_cmd[i], 8'h00);
      chk("loops", lp_exp[i], {ap, aa});
      chk("response", 8'h01, rsp);
    end
    // one autonomous proximity pass, then pause well before the next wake
    cmdp({OP_MERGE_OR, PIX_PROX_RATE}, 8'h01);
    cmdp({OP_MERGE_OR, PIX_WAKE}, 8'h40);
    cmdp(CMD_A_PROX, 8'h00);
    repeat (300) @(negedge ref_clk);
    chk("loop channels", 12'h012, u_meas.seen[11:0]);
    chk("loop response", 8'h01, rsp);
    cmdp(CMD_P_BOTH, 8'h00);
    chk("paused", 0, {ap, aa});
    run(CMD_A_BOTH, 8'h00);
    run(CMD_RESET, 8'h00);
    repeat (50000) @(negedge ref_clk);
    chk("reset response", RSP_RESET, rsp);
    chk("reset loops", 0, {ap, aa});
    allow = 5'h1C;
    mode_a = 8'h70;
    mode_b = 8'h03;
    repeat (5) @(negedge ref_clk);
    chk("standby", 0, awake);
    cmdp(CMD_F_PROX, 8'h00);
    chk("invalid", RSP_INVALID, rsp);
    run({OP_MERGE_OR, PIX_CHANNEL_LIST_PARAM}, 8'h00);
    chk("held invalid", RSP_INVALID, rsp);
    chk("cleared ram", 8'h00, rmb);
    run(CMD_NOP, 8'h00);
    chk("nop clear", RSP_RESET, rsp);
    // channel one in above mode, channel two in crossing mode, both thresholds just under 0x40
    cmdp({OP_MERGE_OR, PIX_CHANNEL_LIST_PARAM}, 8'h03);
    cmdp({OP_MERGE_OR, PIX_TH1}, 8'h3F);
    cmdp({OP_MERGE_OR, PIX_TH1 + 5'h01}, 8'h3F);
    int_clear;
    cmdp(CMD_F_PROX, 8'h00);
    chk("threshold status", 5'h04, ist);
    cmdp({OP_MERGE_OR, PIX_TH1 + 5'h01}, 8'h40);
    int_clear;
    cmdp(CMD_F_PROX, 8'h00);
    chk("crossing status", 5'h0C, ist);
    close_out;
  end
endmodule
